// ---- rtl/nsec_host.sv ----
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`include "nsec_cfg.svh"

module nsec_host
  import nsec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // Flash pins
  output logic             ce_n_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             write_strobe_n_o,
  output logic             read_strobe_n_o,
  output logic             wp_n_o,
  input  wire logic [7:0]  io_i,
  output logic [7:0]       io_o,
  output logic             io_oe_o,
  input  wire logic        ready_busy_pin_i
);
  import nsec_pkg::*;

  nsec_state_t state, next_state;
  logic [`NSEC_CTR_W-1:0] ctr;
  logic [7:0]  cmd;          // Pending bus cycle: code or value
  logic        op_read;      // 1 = read strobe, 0 = command write
  logic        in_serial;    // After 80h or 85h
  logic        in_status;    // Status output mode active
  logic        busy_err;     // Refused command: unknown code, before first ready, while busy or after 80h
  logic        boot_done;    // First ready seen after power-on
  logic [7:0]  result;
  logic        wp_ctl;
  logic [7:0]  io_s;
  logic        rb_s;

  // Pin inputs pass two flops
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_io
      nsec_sync u_io (.clk_i(clk_i), .rst_i(rst_i), .d_i(io_i[g]), .q_o(io_s[g]));
    end
  endgenerate
  nsec_sync u_rb (.clk_i(clk_i), .rst_i(rst_i), .d_i(ready_busy_pin_i), .q_o(rb_s));

  // Bus decode
  wire bus_req   = cyc_i & stb_i & ~ack_o;
  wire wr_ctrl   = bus_req & we_i & sel_i[0] & (adr_i == `NSEC_REG_CTRL);
  wire wr_cmd    = bus_req & we_i & sel_i[0] & (adr_i == `NSEC_REG_CMD);
  wire is_rd_op  = dat_i[8];
  wire idle      = (state == NSEC_IDLE);
  wire ready     = rb_s;

  // Command filter: only listed codes are ever driven onto the pins with io_oe_o high
  wire [7:0] c = dat_i[7:0];
  wire known = (c == `NSEC_CMD_READ) | (c == `NSEC_CMD_PROG) | (c == `NSEC_CMD_MPROG) |
               (c == `NSEC_CMD_STATUS) | (c == `NSEC_CMD_STATUS2) |
               (c == `NSEC_CMD_SERIAL) | (c == `NSEC_CMD_COLCHG) |
               (c == `NSEC_CMD_ECCSTAT) | (c == `NSEC_CMD_ID) |
               (c == `NSEC_CMD_RESET);
  wire busy_ok = (c == `NSEC_CMD_STATUS) | (c == `NSEC_CMD_STATUS2) |
                 (c == `NSEC_CMD_RESET);
  wire ser_ok  = (c == `NSEC_CMD_COLCHG) | (c == `NSEC_CMD_PROG) |
                 (c == `NSEC_CMD_MPROG) | (c == `NSEC_CMD_RESET);
  wire cmd_ok  = known & ((ready & boot_done) | busy_ok)
                 & (~in_serial | ser_ok);
  wire launch  = wr_cmd & idle & (is_rd_op | cmd_ok);
  wire refuse  = wr_cmd & idle & ~is_rd_op & ~cmd_ok;

  // Request as seen at the launch edge itself; latched copies lag one cycle,
  // which would put the previous code on the pins in the first setup cycle
  wire       next_op_read = launch ? is_rd_op : op_read;
  wire [7:0] next_cmd     = launch ? c : cmd;

  // Decoded status fields of the last read byte
  wire st_fail   = result[`NSEC_ST_FAIL_BIT] & result[`NSEC_ST_RDY0_BIT];
  wire st_d_or   = result[`NSEC_ST_D0_BIT] | result[`NSEC_ST_D1_BIT];
  wire st_rewr   = result[`NSEC_ST_REWR_BIT];
  wire st_rdy    = result[`NSEC_ST_RDY0_BIT] & result[`NSEC_ST_RDY1_BIT];
  wire st_wpn    = result[`NSEC_ST_WPN_BIT];
  wire ecc_unc   = (result[3:0] == `NSEC_ECC_UNCORR);
  wire ecc_cnt   = (result[3:0] <= `NSEC_ECC_MAXCORR);
  wire [3:0] ecc_sec = result[7:4];

  // Feature fields when the last read byte was an ID byte; software picks
  // which byte it fetched, so both decodes are offered side by side
  wire [1:0] id_page   = result[1:0];
  wire [1:0] id_blk    = result[5:4];
  wire       id_wide   = result[6];
  wire [1:0] id_planes = result[3:2];
  wire       id_ecc    = result[7];

  // Strobe sequencer
  always_comb begin
    next_state = state;
    case (state)
      NSEC_IDLE:  if (launch) next_state = NSEC_SETUP;
      NSEC_SETUP: if (ctr == '0) next_state = NSEC_PULSE;
      NSEC_PULSE: if (ctr == '0) next_state = NSEC_HOLD;
      NSEC_HOLD:  if (ctr == '0) next_state = NSEC_DONE;
      NSEC_DONE:  next_state = NSEC_IDLE;
      default:    next_state = NSEC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= NSEC_IDLE;
      ctr   <= '0;
    end else begin
      state <= next_state;
      if (next_state != state)
        ctr <= `NSEC_CTR_W'(`NSEC_STROBE_CYC - 1);
      else if (ctr != '0)
        ctr <= ctr - 1'b1;
    end
  end

  // Pin drive; read strobe re-samples status each time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ce_n_o           <= 1'b1;
      cle_o            <= 1'b0;
      ale_o            <= 1'b0;
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o  <= 1'b1;
      io_o             <= 8'h00;
      io_oe_o          <= 1'b0;
    end else begin
      ce_n_o           <= (next_state == NSEC_IDLE);
      cle_o            <= (next_state != NSEC_IDLE) & ~next_op_read;
      io_oe_o          <= (next_state != NSEC_IDLE) & ~next_op_read;
      io_o             <= next_cmd;
      write_strobe_n_o <= ~((next_state == NSEC_PULSE) & ~op_read);
      read_strobe_n_o  <= ~((next_state == NSEC_PULSE) & op_read);
      ale_o            <= 1'b0;
    end
  end

  // Request latch, mode tracking, result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd       <= 8'h00;
      op_read   <= 1'b0;
      in_serial <= 1'b0;
      in_status <= 1'b0;
      busy_err  <= 1'b0;
      boot_done <= 1'b0;
      result    <= 8'h00;
      wp_ctl    <= 1'b0;
      wp_n_o    <= 1'b0;
    end else begin
      wp_n_o <= wp_ctl;
      if (wr_ctrl)
        wp_ctl <= dat_i[`NSEC_CTRL_WP_BIT];
      if (ready)
        boot_done <= 1'b1;
      if (launch) begin
        cmd     <= c;
        op_read <= is_rd_op;
        if (!is_rd_op) begin
          in_serial <= (c == `NSEC_CMD_SERIAL) | (c == `NSEC_CMD_COLCHG);
          in_status <= (c == `NSEC_CMD_STATUS) | (c == `NSEC_CMD_STATUS2);
          if (c == `NSEC_CMD_RESET)
            in_serial <= 1'b0;
        end
      end
      if (refuse)
        busy_err <= 1'b1;
      else if (wr_ctrl && dat_i[`NSEC_CTRL_GO_BIT])
        busy_err <= 1'b0;
      if (state == NSEC_HOLD && op_read && ctr == '0)
        result <= io_s;
    end
  end

  // Register read mux
  wire [31:0] rd_status = {21'h0, ecc_cnt, ecc_unc, st_wpn, st_rdy, st_rewr,
                           st_d_or, st_fail, in_status, in_serial, busy_err, ~idle};
  wire [31:0] rd_result = {12'h0, id_ecc, id_planes, id_wide, id_blk, id_page,
                           ecc_sec, result};
  wire [31:0] rd_mux = (adr_i == `NSEC_REG_CTRL)   ? {30'h0, wp_ctl, 1'b0} :
                       (adr_i == `NSEC_REG_STATUS) ? rd_status :
                       (adr_i == `NSEC_REG_RESULT) ? rd_result :
                       (adr_i == `NSEC_REG_CMD)    ? {24'h0, cmd} : 32'h0;

  // One-cycle Wishbone acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_req;
      dat_o <= rd_mux;
    end
  end
endmodule // nsec_host

// ---- rtl/nsec_cfg.svh ----
`ifndef NSEC_CFG_SVH
`define NSEC_CFG_SVH
// Register offsets (byte addresses, one word each)
`define NSEC_REG_CTRL      8'h00
`define NSEC_REG_STATUS    8'h04
`define NSEC_REG_RESULT    8'h08
`define NSEC_REG_CMD       8'h0C
// Command codes
`define NSEC_CMD_READ      8'h00
`define NSEC_CMD_PROG      8'h10
`define NSEC_CMD_MPROG     8'h11
`define NSEC_CMD_STATUS    8'h70
`define NSEC_CMD_STATUS2   8'h71
`define NSEC_CMD_SERIAL    8'h80
`define NSEC_CMD_COLCHG    8'h85
`define NSEC_CMD_ECCSTAT   8'h7A
`define NSEC_CMD_ID        8'h90
`define NSEC_CMD_RESET     8'hFF
// Control fields
`define NSEC_CTRL_GO_BIT   0
`define NSEC_CTRL_WP_BIT   1
// Status byte fields
`define NSEC_ST_FAIL_BIT   0
`define NSEC_ST_D0_BIT     1
`define NSEC_ST_D1_BIT     2
`define NSEC_ST_REWR_BIT   3
`define NSEC_ST_RDY1_BIT   5
`define NSEC_ST_RDY0_BIT   6
`define NSEC_ST_WPN_BIT    7
// ECC byte fields
`define NSEC_ECC_UNCORR    4'hF
`define NSEC_ECC_MAXCORR   4'h8
// Strobe timing: setup, pulse, hold in cycles of 20 ns
`define NSEC_STROBE_NS     40
`define NSEC_STROBE_CYC    ((`NSEC_STROBE_NS + 19) / 20)
`define NSEC_CTR_W         4
`endif

// ---- rtl/nsec_pkg.sv ----
package nsec_pkg;
  typedef enum logic [4:0] {
    NSEC_IDLE   = 5'b00001,
    NSEC_SETUP  = 5'b00010,
    NSEC_PULSE  = 5'b00100,
    NSEC_HOLD   = 5'b01000,
    NSEC_DONE   = 5'b10000
  } nsec_state_t;
endpackage

// ---- rtl/nsec_sync.sv ----
// Two-stage synchroniser for one pin level
module nsec_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Level
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // nsec_sync

// ---- test/nsec_host_monitor.sv ----
module nsec_host_monitor (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bus and flash pins
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       ack_o,
  input  wire logic       ce_n_o,
  input  wire logic       cle_o,
  input  wire logic       ale_o,
  input  wire logic       write_strobe_n_o,
  input  wire logic       read_strobe_n_o,
  input  wire logic [7:0] io_o,
  input  wire logic       io_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer timing
  chk_ack_once: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  // Strobe framing, code held across the pulse
  chk_cmd_pins: assert property (!write_strobe_n_o |-> !ce_n_o && cle_o && io_oe_o)
    else $error("command strobe framing");
  chk_read_pins: assert property (!read_strobe_n_o |-> !ce_n_o && !cle_o && !io_oe_o)
    else $error("read strobe framing");
  chk_pulse_two: assert property ($fell(write_strobe_n_o) |=> !write_strobe_n_o ##1 write_strobe_n_o)
    else $error("command pulse width");
  chk_read_width: assert property ($fell(read_strobe_n_o) |-> ##1 $stable(read_strobe_n_o)
    ##1 $rose(read_strobe_n_o)) else $error("read pulse width");
  chk_setup_two: assert property ($fell(ce_n_o) |-> ##2 ($fell(write_strobe_n_o) ||
    $fell(read_strobe_n_o))) else $error("strobe setup");
  chk_code_held: assert property (!write_strobe_n_o |-> $stable(io_o) && io_o == $past(io_o, 2))
    else $error("code moved under strobe");
  chk_ce_hold: assert property ($rose(write_strobe_n_o) |-> !ce_n_o [*3] ##1 ce_n_o)
    else $error("enable hold");
  chk_addr_idle: assert property (!ale_o) else $error("address latch raised");
endmodule // nsec_host_monitor

// ---- test/nsec_flash_model.sv ----
module nsec_flash_model (
  // Host pins
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wp_n_i,
  input  wire logic [7:0] cmd_i,
  // Device answers
  output logic [7:0]      io_o,
  output logic            rb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy = 1'b1;
  logic       fail = 1'b0;
  logic       rewr = 1'b0;
  logic [7:0] ecc  = 8'h00;
  logic [7:0] id   = 8'h00;
  logic [7:0] mode = 8'h00;
  logic [7:0] last = 8'h00;
  // Status byte and selected output
  wire [7:0] st   = {wp_n_i, ~busy, ~busy, 1'b0, rewr, 2'b00, fail};
  wire [7:0] dout = (mode == 8'h7A) ? ecc : (mode == 8'h90) ? id : st;
  // Code latched on the rising strobe; reset ends any busy time
  always @(posedge wr_n_i) begin
    if (!ce_n_i && cle_i) begin
      mode <= cmd_i;
      if (cmd_i == 8'hFF) busy <= 1'b0;
    end
  end
  // Fresh byte per strobe; a released line shows the inverse, never a stale value
  always @(negedge rd_n_i) last <= dout;
  assign io_o = (!ce_n_i && !cle_i) ? last : ~last;
  assign rb_o = ~busy;
endmodule // nsec_flash_model

// ---- test/nsec_host_test.sv ----
`include "nsec_cfg.svh"
module nsec_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0;
  wire  [31:0] dat_o;
  wire         ack, ce_n, cle, wr_n, rd_n, wp_n, oe, rb;
  wire  [7:0]  hio, fio;
  int          failures = 0, cmp_count = 0, ws_cnt = 0;
  // Step fields: busy, refused, code; pages are never addressed, order kept
  logic [9:0]  tb [10] = '{10'h390, 10'h310, 10'h270, 10'h271, 10'h2FF,
                           10'h155, 10'h080, 10'h100, 10'h085, 10'h010};
  always #10 clk_i = ~clk_i;
  always @(negedge wr_n) ws_cnt++;
  nsec_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(dat_o),
    .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .ce_n_o(ce_n),
    .cle_o(cle), .ale_o(), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .wp_n_o(wp_n),
    .io_i(oe ? hio : fio), .io_o(hio), .io_oe_o(oe), .ready_busy_pin_i(rb));
  nsec_flash_model i_flash (.ce_n_i(ce_n), .cle_i(cle), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .wp_n_i(wp_n), .cmd_i(hio), .io_o(fio), .rb_o(rb));
  task end_sim;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("BAD %s exp %0h got %0h", nm, e, s);
      failures++;
    end
  endtask
  // Classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (n >= 50) failures++;
  endtask
  task cmd(input logic [8:0] c);
    logic [31:0] q;
    int n;
    n = 0;
    wb(1, `NSEC_REG_CMD, 32'(c), q);
    do wb(0, `NSEC_REG_STATUS, 0, q); while (q[0] !== 1'b0 && ++n < 40);
    if (n >= 40) failures++;
  endtask
  task rd(output logic [31:0] q);
    cmd(9'h100);
    wb(0, `NSEC_REG_RESULT, 0, q);
  endtask
  // Gated codes: power-on, busy, after serial input, unknown
  task t_refuse;
    logic [31:0] q;
    int n;
    for (int i = 0; i < 10; i++) begin
      n = ws_cnt;
      i_flash.busy <= tb[i][9];
      repeat (4) @(posedge clk_i);
      cmd({1'b0, tb[i][7:0]});
      wb(0, `NSEC_REG_STATUS, 0, q);
      chk("refused", 32'(tb[i][8]), 32'(q[1]));
      chk("strobes", 32'(n + !tb[i][8]), 32'(ws_cnt));
      wb(1, `NSEC_REG_CTRL, 32'h3, q);
    end
  endtask
  task t_status;
    logic [31:0] q;
    i_flash.fail = 1;
    cmd(9'h070);
    rd(q);
    chk("status", 32'hE1, 32'(q[7:0]));
    wb(0, `NSEC_REG_STATUS, 0, q);
    chk("st_reg", 32'h33, 32'(q[8:3]));
    i_flash.busy <= 1;
    rd(q);
    chk("poll_busy", 32'h81, 32'(q[7:0]));
    wb(0, `NSEC_REG_STATUS, 0, q);
    chk("fail_busy", 32'h0, 32'(q[4]));
    {i_flash.busy, i_flash.fail, i_flash.rewr} <= 3'b001;
    wb(1, `NSEC_REG_CTRL, 32'h0, q);
    rd(q);
    chk("prot_rewr", 32'h68, 32'(q[7:0]));
    wb(1, `NSEC_REG_CTRL, 32'h2, q);
    wb(0, `NSEC_REG_CTRL, 0, q);
    chk("ctrl_back", 32'h2, q);
  endtask
  task t_ecc;
    logic [31:0] q;
    logic [7:0]  v [4] = '{8'h00, 8'h78, 8'h3F, 8'h51};
    for (int i = 0; i < 4; i++) begin
      i_flash.ecc = v[i];
      cmd({1'b0, `NSEC_CMD_ECCSTAT});
      rd(q);
      chk("ecc", 32'(v[i]), 32'(q[7:0]));
      chk("sector", 32'(v[i][7:4]), 32'(q[11:8]));
      wb(0, `NSEC_REG_STATUS, 0, q);
      chk("uncorr", 32'(v[i][3:0] == 4'hF), 32'(q[9]));
      chk("corr", 32'(v[i][3:0] <= 4'h8), 32'(q[10]));
    end
  endtask
  // Feature bytes: complementary patterns so every field sees both levels
  task t_ident;
    logic [31:0] q;
    logic [7:0]  v [2] = '{8'hD5, 8'h2A};
    for (int i = 0; i < 2; i++) begin
      i_flash.id = v[i];
      cmd({1'b0, `NSEC_CMD_ID});
      rd(q);
      chk("id_page", 32'(v[i][1:0]), 32'(q[13:12]));
      chk("id_block", 32'(v[i][6:4]), 32'(q[16:14]));
      chk("id_plane", 32'({v[i][7], v[i][3:2]}), 32'(q[19:17]));
    end
  endtask
  // Reset ends busy; read command leaves status mode
  task t_reset;
    logic [31:0] q;
    i_flash.busy <= 1;
    repeat (4) @(posedge clk_i);
    cmd(9'h0FF);
    cmd(9'h070);
    wb(0, `NSEC_REG_CMD, 0, q);
    chk("cmd_back", 32'h70, q);
    rd(q);
    chk("reset_rdy", 32'h3, 32'(q[6:5]));
    cmd(9'h000);
    wb(0, `NSEC_REG_STATUS, 0, q);
    chk("in_status", 32'h0, 32'(q[3]));
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    t_refuse;
    t_status;
    t_ecc;
    t_ident;
    t_reset;
    end_sim;
  end
  // Hang guard, well above the expected few hundred cycles
  initial begin
    #1000000;
    failures++;
    end_sim;
  end
endmodule // nsec_host_test
bind nsec_host nsec_host_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o),
  .write_strobe_n_o(write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o), .io_o(io_o),
  .io_oe_o(io_oe_o));
